// ==== include/pss_pkg.sv ====
package pss_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam int CNT_W = 6;
    localparam int DATA_W = 24;
    localparam int LEG_ADDR_W = 6;
    localparam int OPEN_ADDR_W = 5;
    localparam int CHIP_W = 3;
    localparam int SYNC_STAGES = 2;

    // Rising-edge numbers within a frame, counted from one
    localparam logic [CNT_W-1:0] LEG_RW_EDGE = 6'h01;
    localparam logic [CNT_W-1:0] LEG_ADDR_LAST = 6'h07;
    localparam logic [CNT_W-1:0] LEG_DATA_FIRST = 6'h08;
    localparam logic [CNT_W-1:0] LEG_DATA_LAST = 6'h1f;
    localparam logic [CNT_W-1:0] LEG_END_EDGE = 6'h20;
    localparam logic [CNT_W-1:0] OPEN_FIRST_EDGE = 6'h01;
    localparam logic [CNT_W-1:0] OPEN_FULL = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;

    // Open-mode word field positions
    localparam int OPEN_DATA_LSB = 8;
    localparam int OPEN_ADDR_LSB = 3;
    localparam int CHIP_LSB = 0;
    // Legacy data sits one bit up: edge 32 shifts in one extra bit
    localparam int LEG_DATA_LSB = 1;

    // ------------------------------------------------------------------
    // Fixed values and reset values
    // ------------------------------------------------------------------
    localparam logic [CHIP_W-1:0] OWN_CHIP_ADDR = 3'h0;
    localparam logic [OPEN_ADDR_W-1:0] READ_ADDR_REG = 5'h00;
    localparam logic [OPEN_ADDR_W-1:0] RD_FIELD_RST = 5'h00;
    localparam logic [LEG_ADDR_W-1:0] ADDR_RST = 6'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
    localparam logic [FRAME_BITS-1:0] WORD_RST = 32'h00000000;

    typedef enum logic [2:0] {
        PSS_MODE_UNDECIDED = 3'b001,
        PSS_MODE_LEGACY = 3'b010,
        PSS_MODE_OPEN = 3'b100
    } pss_mode_e;

endpackage : pss_pkg

// ==== design/pss_sync.sv ====
`timescale 1ns/100ps
module pss_sync
    import pss_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // ------------------------------------------------------------------
    // Two-stage synchroniser; the first stage feeds only the second
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : pss_sync

// ==== design/pss_shift.sv ====
`timescale 1ns/100ps
module pss_shift
    import pss_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic shift_en,
    input wire logic din,
    output logic [FRAME_BITS-1:0] word_r,
    output logic [CNT_W-1:0] cnt_r
);

    logic [FRAME_BITS-1:0] word_nxt;
    logic [CNT_W-1:0] cnt_nxt;

    // ------------------------------------------------------------------
    // Serial input shifter with saturating edge counter
    // ------------------------------------------------------------------
    // Clear wins over shift so a new frame never inherits a stale bit
    assign word_nxt = clear ? WORD_RST
                    : shift_en ? {word_r[FRAME_BITS-2:0], din} : word_r;
    assign cnt_nxt = clear ? CNT_RST
                   : (shift_en && cnt_r != CNT_MAX)
                     ? cnt_r + 6'h01 : cnt_r;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            word_r <= WORD_RST;
            cnt_r <= CNT_RST;
        end
        else
        begin
            word_r <= word_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule : pss_shift

// ==== design/pss_slave.sv ====
`timescale 1ns/100ps
// How it works
// - Legacy: data-in at first rise after strobe rise; high means read.
// - Legacy read: address bits captured on rising edges two to seven.
// - Legacy read: lock shown no more; 24 data bits out on rises 8-31.
// - Legacy read: output returns to lock indication on rising edge 32.
// - Open mode: 24 data bits MSB first shifted in on first 24 rises.
// - Open mode: 5-bit register address shifted in on rises 25 to 29.
// - Open mode: 3-bit chip address shifted in on rises 30 to 32.
// - Open mode: only chip address 000 is answered.
// - Open mode: strobe rising edge commits the word to its register.
// - Open mode: every frame outputs the register chosen by read field while the line is driven.
// - Open read second cycle: lock off, selected data driven out.
// - Strobe rise after second cycle ends read, lock indication back.
// - Foreign chip address puts the shared output in high impedance.
// - First strobe rise picks legacy, first clock rise picks open mode.
// - Legacy: low data-in on first rise marks a write cycle.
// - Legacy write: 24 data bits captured on rising edges 8 to 31.
// - Open mode: low five bits written to register zero select the read register.
module pss_slave
    import pss_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic port_select_strobe,
    input wire logic serial_data_in,
    input wire logic lock_indicator,
    input wire logic [DATA_W-1:0] rd_data,
    output logic lock_detect_data_out,
    output logic lock_detect_data_oe,
    output logic legacy_single_slave_mode,
    output logic [LEG_ADDR_W-1:0] rd_addr,
    output logic wr_strobe,
    output logic [LEG_ADDR_W-1:0] wr_addr,
    output logic [DATA_W-1:0] wr_data
);

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    logic [2:0] pins_sync;
    logic sclk_s;
    logic sen_s;
    logic sdi_s;
    logic sclk_prev_r;
    logic sen_prev_r;

    pss_sync #(
        .WIDTH(3)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({serial_clk, port_select_strobe, serial_data_in}),
        .sync_out(pins_sync)
    );

    assign sclk_s = pins_sync[2];
    assign sen_s = pins_sync[1];
    assign sdi_s = pins_sync[0];

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sclk_prev_r <= 1'b0;
            sen_prev_r <= 1'b0;
        end
        else
        begin
            sclk_prev_r <= sclk_s;
            sen_prev_r <= sen_s;
        end
    end

    wire sclk_rise = sclk_s && !sclk_prev_r;
    wire sclk_fall = !sclk_s && sclk_prev_r;
    wire sen_rise = sen_s && !sen_prev_r;

    // ------------------------------------------------------------------
    // Mode decision
    // ------------------------------------------------------------------
    pss_mode_e mode_r;
    pss_mode_e mode_nxt;

    // Fixed after the first event; only a reset reopens the choice
    always_comb
    begin
        mode_nxt = mode_r;
        unique case (mode_r)
            PSS_MODE_UNDECIDED:
            begin
                if (sen_rise)
                    mode_nxt = PSS_MODE_LEGACY;
                else if (sclk_rise)
                    mode_nxt = PSS_MODE_OPEN;
            end
            PSS_MODE_LEGACY: mode_nxt = PSS_MODE_LEGACY;
            PSS_MODE_OPEN: mode_nxt = PSS_MODE_OPEN;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            mode_r <= PSS_MODE_UNDECIDED;
        else
            mode_r <= mode_nxt;
    end

    wire in_legacy = (mode_nxt == PSS_MODE_LEGACY);
    wire in_open = (mode_nxt == PSS_MODE_OPEN);

    // ------------------------------------------------------------------
    // Input shifter
    // ------------------------------------------------------------------
    logic [FRAME_BITS-1:0] word;
    logic [CNT_W-1:0] cnt;

    // Legacy frames clock only while the strobe is high; open frames
    // clock while it is low and end on its rising edge.
    wire shift_en = sclk_rise && ((in_legacy && sen_s)
                                  || (in_open && !sen_s));
    wire frame_clear = sen_rise;
    wire [CNT_W-1:0] edge_num = cnt + 6'h01;

    pss_shift u_shift (
        .core_clk(core_clk),
        .rst(rst),
        .clear(frame_clear),
        .shift_en(shift_en),
        .din(sdi_s),
        .word_r(word),
        .cnt_r(cnt)
    );

    // ------------------------------------------------------------------
    // Legacy decode
    // ------------------------------------------------------------------
    logic leg_read_r;
    logic leg_read_nxt;
    logic leg_drive_r;
    logic leg_drive_nxt;

    wire leg_rise = shift_en && in_legacy;
    wire leg_rw_edge = leg_rise && edge_num == LEG_RW_EDGE;
    wire leg_addr_edge = leg_rise && edge_num == LEG_ADDR_LAST;
    wire leg_first_out = leg_rise && leg_read_r
                         && edge_num == LEG_DATA_FIRST;
    wire leg_next_out = leg_rise && leg_drive_r
                        && edge_num > LEG_DATA_FIRST
                        && edge_num <= LEG_DATA_LAST;
    wire leg_out_end = leg_rise && edge_num == LEG_END_EDGE;
    wire [LEG_ADDR_W-1:0] leg_addr_in = {word[LEG_ADDR_W-2:0], sdi_s};
    // Strobe drops with the last clock fall; its prior level qualifies it
    wire leg_commit = in_legacy && sen_prev_r && sclk_fall && !leg_read_r
                      && cnt == LEG_END_EDGE;

    // The read flag is taken from data-in at the first rise
    assign leg_read_nxt = leg_rw_edge ? sdi_s : leg_read_r;
    assign leg_drive_nxt = frame_clear ? 1'b0
                         : leg_first_out ? 1'b1
                         : leg_out_end ? 1'b0
                         : leg_drive_r;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            leg_read_r <= 1'b0;
            leg_drive_r <= 1'b0;
        end
        else
        begin
            leg_read_r <= leg_read_nxt;
            leg_drive_r <= leg_drive_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Open-mode decode
    // ------------------------------------------------------------------
    logic [OPEN_ADDR_W-1:0] rd_field_r;
    logic [OPEN_ADDR_W-1:0] rd_field_nxt;
    logic open_drive_r;
    logic open_drive_nxt;
    logic hiz_r;
    logic hiz_nxt;

    wire [CHIP_W-1:0] open_chip = word[CHIP_LSB +: CHIP_W];
    wire [OPEN_ADDR_W-1:0] open_addr
        = word[OPEN_ADDR_LSB +: OPEN_ADDR_W];
    wire [DATA_W-1:0] open_data = word[OPEN_DATA_LSB +: DATA_W];
    wire open_end = in_open && sen_rise && mode_r == PSS_MODE_OPEN;
    wire open_full = cnt >= OPEN_FULL;
    wire chip_match = open_chip == OWN_CHIP_ADDR;
    wire open_commit = open_end && open_full && chip_match;
    wire open_first_out = shift_en && in_open
                          && edge_num == OPEN_FIRST_EDGE;
    wire open_next_out = shift_en && in_open && open_drive_r
                         && edge_num > OPEN_FIRST_EDGE;

    // Register zero carries the read-back pointer in its low bits
    assign rd_field_nxt = (open_commit && open_addr == READ_ADDR_REG)
                          ? open_data[OPEN_ADDR_W-1:0]
                          : rd_field_r;
    // Data leaves on every open frame until the strobe rises
    assign open_drive_nxt = open_end ? 1'b0
                          : open_first_out ? 1'b1
                          : open_drive_r;
    // A frame for another chip releases the shared line until a full frame
    // for this chip ends; two drivers on one line would fight.
    assign hiz_nxt = (open_end && open_full) ? !chip_match
                   : hiz_r;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rd_field_r <= RD_FIELD_RST;
            open_drive_r <= 1'b0;
            hiz_r <= 1'b0;
        end
        else
        begin
            rd_field_r <= rd_field_nxt;
            open_drive_r <= open_drive_nxt;
            hiz_r <= hiz_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read-back shifter and shared output
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] out_sh_r;
    logic [DATA_W-1:0] out_sh_nxt;
    logic sdo_bit_r;
    logic sdo_bit_nxt;

    wire load_out = leg_first_out || open_first_out;
    wire step_out = leg_next_out || open_next_out;
    wire drive_nxt = leg_drive_nxt || open_drive_nxt;

    // MSB leaves first; zeros follow once the word is spent
    assign out_sh_nxt = load_out ? {rd_data[DATA_W-2:0], 1'b0}
                      : step_out ? {out_sh_r[DATA_W-2:0], 1'b0}
                      : out_sh_r;
    assign sdo_bit_nxt = load_out ? rd_data[DATA_W-1]
                       : step_out ? out_sh_r[DATA_W-1]
                       : sdo_bit_r;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            out_sh_r <= DATA_RST;
            sdo_bit_r <= 1'b0;
        end
        else
        begin
            out_sh_r <= out_sh_nxt;
            sdo_bit_r <= sdo_bit_nxt;
        end
    end

    // Output trails the sampled clock edge by the synchroniser delay plus one output register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            lock_detect_data_out <= 1'b0;
            lock_detect_data_oe <= 1'b1;
        end
        else
        begin
            lock_detect_data_out <= drive_nxt ? sdo_bit_nxt
                                  : lock_indicator;
            lock_detect_data_oe <= !hiz_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register access ports
    // ------------------------------------------------------------------
    wire [LEG_ADDR_W-1:0] rd_addr_nxt
        = leg_addr_edge ? leg_addr_in
        : in_open ? {1'b0, rd_field_r}
        : rd_addr;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rd_addr <= ADDR_RST;
            wr_strobe <= 1'b0;
            wr_addr <= ADDR_RST;
            wr_data <= DATA_RST;
            legacy_single_slave_mode <= 1'b0;
        end
        else
        begin
            rd_addr <= rd_addr_nxt;
            wr_strobe <= leg_commit || open_commit;
            legacy_single_slave_mode <= in_legacy;
            if (leg_commit)
            begin
                wr_addr <= word[LEG_DATA_LSB+DATA_W +: LEG_ADDR_W];
                wr_data <= word[LEG_DATA_LSB +: DATA_W];
            end
            else if (open_commit)
            begin
                wr_addr <= {1'b0, open_addr};
                wr_data <= open_data;
            end
        end
    end

endmodule : pss_slave

// ==== verif/pss_slave_checker.sv ====
`timescale 1ns/100ps
module pss_slave_checker
    import pss_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic port_select_strobe,
    input wire logic serial_data_in,
    input wire logic lock_indicator,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic lock_detect_data_out,
    input wire logic lock_detect_data_oe,
    input wire logic legacy_single_slave_mode,
    input wire logic [LEG_ADDR_W-1:0] rd_addr,
    input wire logic wr_strobe,
    input wire logic [LEG_ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Steps of a transfer
    // ----------------------------------------------------------------
    // Pin edges reach the logic through the syncs a few cycles late
    sequence s_strobe_quiet;
        !port_select_strobe [*5];
    endsequence
    sequence s_strobe_seen;
        $past(port_select_strobe, 3);
    endsequence
    sequence s_strobe_dropped;
        !port_select_strobe && $past(port_select_strobe, 8);
    endsequence

    a_legacy_lock_shown: assert property (
        s_strobe_quiet ##0 legacy_single_slave_mode
        |-> lock_detect_data_out == $past(lock_indicator))
        else $error("lock level not shown while idle");
    a_legacy_commit_late: assert property (
        legacy_single_slave_mode && wr_strobe |-> s_strobe_dropped)
        else $error("legacy commit before strobe fall");
    a_open_commit_edge: assert property (
        !legacy_single_slave_mode && wr_strobe |-> s_strobe_seen)
        else $error("open commit without strobe rise");
    a_open_addr_narrow: assert property (
        !legacy_single_slave_mode
        |-> !wr_addr[5] && !rd_addr[5])
        else $error("open address above five bits");
    a_commit_one_pulse: assert property (
        wr_strobe |=> !wr_strobe)
        else $error("commit pulse too long");
    a_commit_data_held: assert property (
        !wr_strobe |-> $stable(wr_addr) && $stable(wr_data))
        else $error("commit data moved without pulse");
    a_mode_stays_put: assert property (
        legacy_single_slave_mode |=> legacy_single_slave_mode)
        else $error("legacy mode left without reset");
    a_mode_by_strobe: assert property (
        $rose(legacy_single_slave_mode) |-> s_strobe_seen)
        else $error("legacy mode without strobe rise");
    a_foreign_tristate: assert property (
        $fell(lock_detect_data_oe)
        |-> !legacy_single_slave_mode ##0 s_strobe_seen)
        else $error("output released outside open frame end");
    a_legacy_drives: assert property (
        legacy_single_slave_mode |-> lock_detect_data_oe)
        else $error("legacy output not driven");
endmodule : pss_slave_checker

// ==== verif/pss_host_model.sv ====
`timescale 1ns/100ps
module pss_host_model
    import pss_pkg::*;
(
    input wire logic core_clk,
    input wire logic lock_detect_data_out,
    input wire logic lock_detect_data_oe,
    output logic serial_clk,
    output logic port_select_strobe,
    output logic serial_data_in
);
    logic last_r = 1'b0;
    logic line_level;

    // Unpulled shared line: a released driver leaves the inverse behind
    assign line_level = lock_detect_data_oe ? lock_detect_data_out : ~last_r;
    always @(posedge core_clk)
        if (lock_detect_data_oe)
            last_r <= lock_detect_data_out;

    initial
    begin
        serial_clk = 1'b0;
        port_select_strobe = 1'b0;
        serial_data_in = 1'b0;
    end

    task automatic wait_neg(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_neg

    // ----------------------------------------------------------------
    // One frame: clock stands still outside it, 4 cycles per phase
    // ----------------------------------------------------------------
    // Read bits are taken late in the low phase since the output
    // trails the clock edge by two and a half core clock cycles.
    task automatic frame(input logic legacy, input logic [31:0] bits,
        input int rises, output logic [23:0] got);
        got = 24'h000000;
        port_select_strobe = legacy;
        serial_data_in = bits[31];
        wait_neg(4);
        for (int i = 1; i <= rises; i++)
        begin
            serial_clk = 1'b1;
            wait_neg(4);
            serial_clk = 1'b0;
            if (legacy && i == 32)
                port_select_strobe = 1'b0;
            // Past the frame the data line is no longer held
            if (i < 32)
                serial_data_in = bits[31-i];
            else
                serial_data_in = ~serial_data_in;
            wait_neg(3);
            if ((legacy && i >= 8 && i <= 31) || (!legacy && i <= 24))
                got = {got[22:0], line_level};
            wait_neg(1);
        end
        port_select_strobe = !legacy;
        wait_neg(4);
        port_select_strobe = 1'b0;
        wait_neg(4);
    endtask : frame
endmodule : pss_host_model

// ==== verif/pss_slave_tb.sv ====
`timescale 1ns/100ps
module pss_slave_tb
    import pss_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic lock_indicator = 1'b0;
    logic serial_clk, port_select_strobe, serial_data_in, wr_strobe;
    logic lock_detect_data_out, lock_detect_data_oe, legacy_single_slave_mode;
    logic [DATA_W-1:0] rd_data, wr_data, got, d;
    logic [LEG_ADDR_W-1:0] rd_addr, wr_addr, a;
    logic [DATA_W-1:0] mem [0:63];
    logic [29:0] commits [$];
    logic drv = 1'b1;
    int seed = 71;
    int checked = 0;
    int mismatches = 0;
    int cycles = 0;
    int field = 0;

    always #5 core_clk = ~core_clk;
    assign rd_data = mem[rd_addr];
    always @(negedge core_clk) lock_indicator <= 1'($random(seed));

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (wr_strobe === 1'b1)
            commits.push_back({wr_addr, wr_data});
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    pss_host_model host_u (.core_clk(core_clk),
        .lock_detect_data_out(lock_detect_data_out),
        .lock_detect_data_oe(lock_detect_data_oe), .serial_clk(serial_clk),
        .port_select_strobe(port_select_strobe),
        .serial_data_in(serial_data_in));
    pss_slave dut_u (.core_clk(core_clk), .rst(rst),
        .serial_clk(serial_clk), .port_select_strobe(port_select_strobe),
        .serial_data_in(serial_data_in), .lock_indicator(lock_indicator),
        .rd_data(rd_data), .lock_detect_data_out(lock_detect_data_out),
        .lock_detect_data_oe(lock_detect_data_oe),
        .legacy_single_slave_mode(legacy_single_slave_mode),
        .rd_addr(rd_addr), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
        .wr_data(wr_data));

    // ----------------------------------------------------------------
    // Compare tasks and the bench model
    // ----------------------------------------------------------------
    task automatic cmp_word(input string what, input logic [23:0] exp,
        input logic [23:0] seen);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp_word

    // Each frame leaves at most one commit behind
    task automatic cmp_commit(input logic due, input logic [29:0] exp);
        logic [29:0] seen;
        repeat (8) @(negedge core_clk);
        seen = 30'h3fffffff;
        if (commits.size() > 0)
            seen = commits.pop_front();
        if (!due)
            exp = 30'h3fffffff;
        checked++;
        if (seen !== exp || commits.size() != 0)
        begin
            mismatches++;
            $display("mismatch commit expected %h seen %h", exp, seen);
        end
    endtask : cmp_commit

    task automatic cmp_lock();
        @(posedge core_clk);
        #1;
        cmp_word("lock", {23'h0, lock_indicator},
            {23'h0, lock_detect_data_out});
    endtask : cmp_lock

    task automatic open_op(input logic [4:0] r, input logic [23:0] v,
        input logic [2:0] chip, input int rises);
        logic was_drv;
        logic ok;
        was_drv = drv;
        ok = (chip == 3'h0) && (rises >= 32);
        host_u.frame(1'b0, {v, r, chip}, rises, got);
        if (was_drv && rises == 32)
            cmp_word("open read", mem[field], got);
        cmp_commit(ok, {1'b0, r, v});
        if (ok && r == 5'h00)
            field = int'(v[4:0]);
        if (rises >= 32)
            drv = ok;
        cmp_word("oe", {23'h0, drv}, {23'h0, lock_detect_data_oe});
        if (drv)
            cmp_lock();
    endtask : open_op

    task automatic do_reset();
        rst = 1'b1;
        host_u.serial_data_in = 1'b0;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask : do_reset

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 24'($random(seed));
        do_reset();
        for (int i = 0; i < 6; i++)
        begin
            a = (i == 0) ? 6'h3f : 6'($random(seed));
            d = 24'($random(seed));
            host_u.frame(1'b1, {i[0], a, d, 1'b0}, 32, got);
            if (i[0])
                cmp_commit(1'b0, 30'h0);
            else
                cmp_commit(1'b1, {a, d});
            if (i[0])
                cmp_word("legacy read", mem[a], got);
            cmp_lock();
        end
        cmp_word("mode", 24'h1, {23'h0, legacy_single_slave_mode});
        host_u.frame(1'b1, {1'b0, a, d, 1'b0}, 20, got);
        cmp_commit(1'b0, 30'h0);
        $display("legacy tests done");

        do_reset();
        field = 0;
        drv = 1'b1;
        open_op(5'($random(seed)), 24'($random(seed)), 3'h0, 32);
        cmp_word("mode", 24'h0, {23'h0, legacy_single_slave_mode});
        d = {19'h0, 5'($random(seed))};
        open_op(5'h00, d, 3'h0, 32);
        open_op(5'h00, d, 3'h0, 32);
        for (int c = 1; c < 8; c++)
            open_op(5'($random(seed)), 24'($random(seed)),
                3'(c), 32);
        open_op(5'h00, 24'h00001f, 3'h0, 20);
        open_op(5'h00, 24'h00001f, 3'h0, 32);
        open_op(5'($random(seed)), 24'($random(seed)), 3'h0, 32);
        $display("open mode tests done");
        end_of_test();
    end
endmodule : pss_slave_tb

bind pss_slave pss_slave_checker chk_u (.core_clk(core_clk), .rst(rst),
    .serial_clk(serial_clk), .port_select_strobe(port_select_strobe),
    .serial_data_in(serial_data_in), .lock_indicator(lock_indicator),
    .rd_data(rd_data), .lock_detect_data_out(lock_detect_data_out),
    .lock_detect_data_oe(lock_detect_data_oe),
    .legacy_single_slave_mode(legacy_single_slave_mode),
    .rd_addr(rd_addr), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data));
